/* File: asp_pkg.sv */
`default_nettype none
package asp_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned REG_AW = 3;
    localparam logic [2:0] REG_SERIAL_CONTROL = 3'h0;
    localparam logic [2:0] REG_SERIAL_BUFFER = 3'h1;
    localparam logic [2:0] REG_POWER_CONTROL = 3'h2;
    localparam logic [2:0] REG_SLAVE_ADDR = 3'h3;
    localparam logic [2:0] REG_SLAVE_ADDR_MASK = 3'h4;
    // serial_control fields.
    localparam int unsigned SC_MODE_UPPER = 7;
    localparam int unsigned SC_MODE_LOWER = 6;
    localparam int unsigned SC_MULTIPROC = 5;
    localparam int unsigned SC_RX_ENABLE = 4;
    localparam int unsigned SC_TX_NINTH = 3;
    localparam int unsigned SC_RX_NINTH = 2;
    localparam int unsigned SC_TX_DONE = 1;
    localparam int unsigned SC_RX_DONE = 0;
    // power_control fields.
    localparam int unsigned PC_BAUD_DOUBLE = 7;
    localparam int unsigned PC_FRAME_FLAG_SEL = 6;
    // Reset values.
    localparam logic [7:0] SERIAL_CONTROL_RST = 8'h00;
    localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
    localparam logic [7:0] SLAVE_ADDR_RST = 8'h00;
    localparam logic [7:0] SLAVE_ADDR_MASK_RST = 8'h00;
    localparam logic [7:0] SERIAL_BUFFER_RST = 8'h00;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam logic [3:0] DIV16_LAST = 4'hf;
    localparam logic [3:0] VOTE_FIRST = 4'h7;
    localparam logic [3:0] VOTE_SECOND = 4'h8;
    localparam logic [3:0] VOTE_THIRD = 4'h9;
    localparam logic [3:0] FRAME_BITS_10 = 4'ha;
    localparam logic [3:0] FRAME_BITS_11 = 4'hb;
    // Sixteen-times ticks: every 4 or 2 clocks gives clk/64 or clk/32
    // bit rate; every 2 or 1 overflows gives overflow/32 or /16.
    localparam logic [1:0] PRE_OSC_SLOW = 2'h3;
    localparam logic [1:0] PRE_OSC_FAST = 2'h1;
    localparam logic [1:0] PRE_TMR_SLOW = 2'h1;
    localparam logic [1:0] PRE_TMR_FAST = 2'h0;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SYNC8 = 2'b00,
        MODE_TMR10 = 2'b01,
        MODE_OSC11 = 2'b10,
        MODE_TMR11 = 2'b11
    } asp_mode_type;
    typedef enum logic {
        RX_HUNT = 1'b0,
        RX_FRAME = 1'b1
    } asp_rx_state_type;
endpackage : asp_pkg
`default_nettype wire

/* File: asp_top.sv */
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module asp_top
    import asp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [REG_AW-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic timer_ovf_i,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic tx_done_o,
    output logic rx_done_o
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic vote3(input logic a, input logic b, input logic c);
        return (a & b) | (a & c) | (b & c);
    endfunction : vote3

    function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] sa,
                                      input logic [7:0] sm);
        logic [7:0] bc;
        bc = sa | sm;
        return (((rx ^ sa) & sm) == 8'h00) || (((rx ^ bc) & bc) == 8'h00);
    endfunction : addr_hit

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic mode_upper_q, mode_lower_q, multiproc_q, rx_enable_q;
    logic tx_ninth_q, rx_ninth_q, tx_done_q, rx_done_q, frame_err_q;
    logic baud_double_q, frame_flag_sel_q;
    logic [7:0] slave_addr_q, slave_mask_q, rx_buf_q, tx_data_q;
    logic [7:0] rd_mux;
    logic [7:0] reg_rdata_q;
    logic wr_ctrl, wr_buf, wr_pc;
    asp_mode_type mode;
    logic async_mode, eleven;

    assign wr_ctrl = reg_wr_i && (reg_addr_i == REG_SERIAL_CONTROL);
    assign wr_buf = reg_wr_i && (reg_addr_i == REG_SERIAL_BUFFER);
    assign wr_pc = reg_wr_i && (reg_addr_i == REG_POWER_CONTROL);
    assign mode = asp_mode_type'({mode_upper_q, mode_lower_q});
    assign async_mode = (mode != MODE_SYNC8);
    assign eleven = (mode == MODE_OSC11) || (mode == MODE_TMR11);

    // Events from the receiver and transmitter.
    logic tx_set, rx_load, fe_set;
    logic [7:0] rx_byte;
    logic rx_nb;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            {mode_upper_q, mode_lower_q, multiproc_q, rx_enable_q} <= SERIAL_CONTROL_RST[7:4];
            tx_ninth_q <= SERIAL_CONTROL_RST[SC_TX_NINTH];
        end else if (wr_ctrl) begin
            if (!frame_flag_sel_q) begin
                mode_upper_q <= reg_wdata_i[SC_MODE_UPPER];
            end
            mode_lower_q <= reg_wdata_i[SC_MODE_LOWER];
            multiproc_q <= reg_wdata_i[SC_MULTIPROC];
            rx_enable_q <= reg_wdata_i[SC_RX_ENABLE];
            tx_ninth_q <= reg_wdata_i[SC_TX_NINTH];
        end
    end

    // Hardware sets win over a software write in the same cycle.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_done_q <= SERIAL_CONTROL_RST[SC_TX_DONE];
            rx_done_q <= SERIAL_CONTROL_RST[SC_RX_DONE];
            rx_ninth_q <= SERIAL_CONTROL_RST[SC_RX_NINTH];
            frame_err_q <= 1'b0;
        end else begin
            if (tx_set) begin
                tx_done_q <= 1'b1;
            end else if (wr_ctrl) begin
                tx_done_q <= reg_wdata_i[SC_TX_DONE];
            end
            if (rx_load) begin
                rx_done_q <= 1'b1;
                rx_ninth_q <= rx_nb;
            end else if (wr_ctrl) begin
                rx_done_q <= reg_wdata_i[SC_RX_DONE];
                rx_ninth_q <= reg_wdata_i[SC_RX_NINTH];
            end
            if (fe_set) begin
                frame_err_q <= 1'b1;
            end else if (wr_ctrl && frame_flag_sel_q) begin
                frame_err_q <= reg_wdata_i[SC_MODE_UPPER];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            baud_double_q <= POWER_CONTROL_RST[PC_BAUD_DOUBLE];
            frame_flag_sel_q <= POWER_CONTROL_RST[PC_FRAME_FLAG_SEL];
        end else if (wr_pc) begin
            baud_double_q <= reg_wdata_i[PC_BAUD_DOUBLE];
            frame_flag_sel_q <= reg_wdata_i[PC_FRAME_FLAG_SEL];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            slave_addr_q <= SLAVE_ADDR_RST;
            slave_mask_q <= SLAVE_ADDR_MASK_RST;
        end else if (reg_wr_i && (reg_addr_i == REG_SLAVE_ADDR)) begin
            slave_addr_q <= reg_wdata_i;
        end else if (reg_wr_i && (reg_addr_i == REG_SLAVE_ADDR_MASK)) begin
            slave_mask_q <= reg_wdata_i;
        end
    end

    // Two buffers share one address: writes go out, reads come in.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_buf_q <= SERIAL_BUFFER_RST;
            tx_data_q <= SERIAL_BUFFER_RST;
        end else begin
            if (rx_load) begin
                rx_buf_q <= rx_byte;
            end
            if (wr_buf) begin
                tx_data_q <= reg_wdata_i;
            end
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr_i == REG_SERIAL_CONTROL) begin
            rd_mux = {frame_flag_sel_q ? frame_err_q : mode_upper_q,
                      mode_lower_q, multiproc_q, rx_enable_q,
                      tx_ninth_q, rx_ninth_q, tx_done_q, rx_done_q};
        end else if (reg_addr_i == REG_SERIAL_BUFFER) begin
            rd_mux = rx_buf_q;
        end else if (reg_addr_i == REG_POWER_CONTROL) begin
            rd_mux = {baud_double_q, frame_flag_sel_q, 6'h00};
        end else if (reg_addr_i == REG_SLAVE_ADDR) begin
            rd_mux = slave_addr_q;
        end else if (reg_addr_i == REG_SLAVE_ADDR_MASK) begin
            rd_mux = slave_mask_q;
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_q <= rd_mux;
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end
    assign reg_rdata_o = reg_rdata_q;

    // ----------------------------------------------------------------
    // Baud tick at sixteen times the bit rate
    // ----------------------------------------------------------------
    logic [1:0] pre_q, pre_lim;
    logic pre_src, tick;
    assign pre_src = (mode == MODE_OSC11) ? 1'b1 : timer_ovf_i;
    always_comb begin
        if (mode == MODE_OSC11) begin
            pre_lim = baud_double_q ? PRE_OSC_FAST : PRE_OSC_SLOW;
        end else begin
            pre_lim = baud_double_q ? PRE_TMR_FAST : PRE_TMR_SLOW;
        end
    end
    assign tick = pre_src && (pre_q >= pre_lim) && async_mode;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pre_q <= 2'h0;
        end else if (tick) begin
            pre_q <= 2'h0;
        end else if (pre_src) begin
            pre_q <= pre_q + 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    logic [3:0] tx_div_q, tx_left_q;
    logic [9:0] tx_shift_q;
    logic tx_pend_q, tx_line_q, tx_roll, tx_start;
    assign tx_roll = tick && (tx_div_q == DIV16_LAST);
    // A write is held until the next rollover, so the frame is never
    // aligned to the write itself. A write mid-frame waits its turn.
    assign tx_start = tx_roll && tx_pend_q && (tx_left_q == 4'h0);
    assign tx_set = tx_roll && (tx_left_q == 4'h1);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_div_q <= 4'h0;
        end else if (tick) begin
            tx_div_q <= tx_div_q + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_pend_q <= 1'b0;
        end else if (wr_buf) begin
            tx_pend_q <= 1'b1;
        end else if (tx_start) begin
            tx_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_left_q <= 4'h0;
            tx_shift_q <= 10'h3ff;
            tx_line_q <= 1'b1;
        end else if (tx_start) begin
            tx_line_q <= 1'b0;
            tx_left_q <= (eleven ? FRAME_BITS_11 : FRAME_BITS_10) - 4'h1;
            tx_shift_q <= {1'b1, eleven ? tx_ninth_q : 1'b1, tx_data_q};
        end else if (tx_roll && (tx_left_q != 4'h0)) begin
            tx_line_q <= tx_shift_q[0];
            tx_shift_q <= {1'b1, tx_shift_q[9:1]};
            tx_left_q <= tx_left_q - 4'h1;
        end
    end
    assign serial_out_pin_o = tx_line_q;
    assign tx_done_o = tx_done_q;
    assign rx_done_o = rx_done_q;

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    logic in_meta_q, in_sync_q, in_prev_q, fall;
    logic [3:0] rx_div_q, rx_bit_q, rx_last;
    logic [1:0] samp_q;
    logic [8:0] rx_shift_q;
    logic vote_now, v, rx_end;
    asp_rx_state_type rx_st_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            in_meta_q <= 1'b1;
            in_sync_q <= 1'b1;
        end else begin
            in_meta_q <= serial_in_pin_i;
            in_sync_q <= in_meta_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            in_prev_q <= 1'b1;
        end else if (tick) begin
            in_prev_q <= in_sync_q;
        end
    end

    assign fall = tick && in_prev_q && !in_sync_q && rx_enable_q;
    assign vote_now = tick && (rx_st_q == RX_FRAME) && (rx_div_q == VOTE_THIRD);
    assign v = vote3(samp_q[1], samp_q[0], in_sync_q);
    assign rx_last = (eleven ? FRAME_BITS_11 : FRAME_BITS_10) - 4'h1;
    assign rx_end = vote_now && (rx_bit_q == rx_last);
    assign rx_byte = eleven ? rx_shift_q[7:0] : rx_shift_q[8:1];
    assign rx_nb = eleven ? rx_shift_q[8] : v;
    assign rx_load = rx_end && !rx_done_q &&
                     (!multiproc_q || (rx_nb &&
                      addr_hit(rx_byte, slave_addr_q, slave_mask_q)));
    assign fe_set = rx_end && !v;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_div_q <= 4'h0;
        end else if ((rx_st_q == RX_HUNT) && fall) begin
            rx_div_q <= 4'h0;
        end else if (tick) begin
            rx_div_q <= rx_div_q + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            samp_q <= 2'b11;
        end else if (tick && ((rx_div_q == VOTE_FIRST) || (rx_div_q == VOTE_SECOND))) begin
            samp_q <= {samp_q[0], in_sync_q};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_st_q <= RX_HUNT;
            rx_bit_q <= 4'h0;
            rx_shift_q <= 9'h000;
        end else begin
            case (rx_st_q)
                RX_HUNT: begin
                    if (fall && async_mode) begin
                        rx_st_q <= RX_FRAME;
                        rx_bit_q <= 4'h0;
                    end
                end
                RX_FRAME: begin
                    if (vote_now) begin
                        if ((rx_bit_q == 4'h0) && v) begin
                            rx_st_q <= RX_HUNT;
                        end else if (rx_bit_q == rx_last) begin
                            rx_st_q <= RX_HUNT;
                        end else begin
                            if (rx_bit_q != 4'h0) begin
                                rx_shift_q <= {v, rx_shift_q[8:1]};
                            end
                            rx_bit_q <= rx_bit_q + 4'h1;
                        end
                    end
                end
                default: begin
                    rx_st_q <= RX_HUNT;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_tx_start_low: assert property (tx_start |=> !serial_out_pin_o)
        else $error("start bit not driven low");
    a_tx_done_stop: assert property (tx_set |=> tx_done_o && serial_out_pin_o)
        else $error("tx done without stop bit on the line");
    a_tx_pend_hold: assert property (tx_pend_q && !tx_roll |=> tx_pend_q)
        else $error("pending transmit lost");
    a_rx_edge_align: assert property ((rx_st_q == RX_HUNT) && fall && async_mode
        |=> (rx_st_q == RX_FRAME) && (rx_div_q == 4'h0))
        else $error("receiver did not align to falling edge");
    a_rx_false_start: assert property (vote_now && (rx_bit_q == 4'h0) && v
        |=> rx_st_q == RX_HUNT)
        else $error("false start not rejected");
    a_rx_load_guard: assert property (rx_load |-> !rx_done_q
        && (!multiproc_q || rx_nb))
        else $error("receive buffer loaded against its conditions");
    a_rx_load_data: assert property (rx_load |=> rx_buf_q == $past(rx_byte)
        && rx_done_o)
        else $error("receive buffer not updated on load");
    a_fe_sticky: assert property (frame_err_q && !(wr_ctrl && frame_flag_sel_q)
        |=> frame_err_q)
        else $error("frame error flag lost");
    a_done_sticky: assert property (rx_done_q && !wr_ctrl |=> rx_done_q)
        else $error("receive done flag cleared by hardware");
    a_buf_read: assert property (reg_rd_i && (reg_addr_i == REG_SERIAL_BUFFER)
        |=> reg_rdata_o == $past(rx_buf_q))
        else $error("buffer read did not return receive data");
    a_reset_addr: assert property ($rose(rst_n_i) |-> (slave_addr_q == 8'h00)
        && (slave_mask_q == 8'h00))
        else $error("address registers not cleared by reset");

    c_rx_frame_loaded: cover property (rx_load);
    c_tx_frame_done: cover property (tx_set);
    c_frame_error: cover property (fe_set);
    c_false_start: cover property (vote_now && (rx_bit_q == 4'h0) && v);
endmodule : asp_top
`default_nettype wire

/* File: asp_peer_model.sv */
`timescale 1ns/10ps
`default_nettype none
module asp_peer_model (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    initial line_o = 1'b1;
    // Frames go out LSB first and the line rests high between them.
    task automatic send(input int nb, input int per, input logic [10:0] f);
        for (int i = 0; i < nb; i++) begin
            @(posedge clk_i);
            line_o <= f[i];
            repeat (per - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        line_o <= 1'b1;
    endtask : send
    // Samples in mid-bit; the wait for a start is bounded so a dead line cannot hang.
    task automatic catch(input int per, output logic [10:0] f);
        int n;
        n = 0;
        f = 11'h7ff;
        while (line_i !== 1'b0 && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
        repeat (per / 2) @(posedge clk_i);
        for (int i = 0; i < 11; i++) begin
            f[i] = line_i;
            repeat (per) @(posedge clk_i);
        end
    endtask : catch
endmodule : asp_peer_model
`default_nettype wire

/* File: async_serial_port_multiproc_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module async_serial_port_multiproc_tb_top
    import asp_pkg::*;
;
    typedef struct packed {
        logic [1:0] mode;
        logic bd;
        logic mpe;
        logic [7:0] sa;
        logic [7:0] sm;
        logic [7:0] data;
        logic ninth;
        logic load;
    } asp_row_type;
    logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, timer_ovf_i, rxd, txd, tx_done_o, rx_done_o;
    logic [REG_AW-1:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, rd_q;
    logic [10:0] got, exp_f;
    int fail_count = 0;
    int checks = 0;
    int per;
    asp_row_type r;
    asp_row_type rows [0:8] = '{
        '{2'b10, 1'b1, 1'b0, 8'h00, 8'h00, 8'ha5, 1'b0, 1'b1},
        '{2'b10, 1'b0, 1'b1, 8'ha4, 8'hfa, 8'ha0, 1'b1, 1'b1},
        '{2'b11, 1'b1, 1'b1, 8'ha4, 8'hfa, 8'ha0, 1'b0, 1'b0},
        '{2'b11, 1'b1, 1'b1, 8'ha4, 8'hfa, 8'ha2, 1'b1, 1'b0},
        '{2'b01, 1'b1, 1'b0, 8'h00, 8'h00, 8'h3c, 1'b1, 1'b1},
        '{2'b01, 1'b0, 1'b1, 8'ha7, 8'hf9, 8'ha3, 1'b1, 1'b1},
        '{2'b01, 1'b1, 1'b1, 8'ha7, 8'hf9, 8'ha0, 1'b1, 1'b0},
        '{2'b01, 1'b1, 1'b1, 8'h00, 8'h00, 8'h55, 1'b0, 1'b0},
        '{2'b10, 1'b1, 1'b1, 8'ha4, 8'hfa, 8'hfe, 1'b1, 1'b1}};

    asp_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .timer_ovf_i(timer_ovf_i), .serial_in_pin_i(rxd),
        .serial_out_pin_o(txd), .tx_done_o(tx_done_o), .rx_done_o(rx_done_o));
    asp_peer_model u_peer (.clk_i(clk_i), .line_i(txd), .line_o(rxd));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // Overflow every second clock, so the timer modes match the fixed mode's rates.
    always @(posedge clk_i) timer_ovf_i <= rst_n_i ? ~timer_ovf_i : 1'b0;

    // ----------------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] seen);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic chk_flag(input string what, input logic exp, input logic seen);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, seen);
        end
    endtask : chk_flag
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_i);
        rd_q = reg_rdata_o;
    endtask : rd
    task automatic rx_frame(input int p, input logic [7:0] d, input logic n);
        u_peer.send(11, p, {1'b1, n, d, 1'b0});
        repeat (4) @(posedge clk_i);
    endtask : rx_frame
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out

    initial begin
        repeat (60000) @(posedge clk_i);
        fail_count++;
        $display("watchdog expired");
        close_out();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 3'h0;
        reg_wdata_i = 8'h00;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int a = 0; a < 6; a++) begin
            rd(a[2:0]);
            chk("reset value", 11'h000, {3'h0, rd_q});
        end
        $display("test reset done");
        foreach (rows[i]) begin
            r = rows[i];
            per = r.bd ? 32 : 64;
            wr(REG_POWER_CONTROL, {r.bd, 7'h00});
            wr(REG_SLAVE_ADDR, r.sa);
            wr(REG_SLAVE_ADDR_MASK, r.sm);
            wr(REG_SERIAL_CONTROL, {r.mode, r.mpe, 1'b1, r.ninth, 3'h0});
            rx_frame(per, r.data, r.ninth);
            chk_flag("rx_done", r.load, rx_done_o);
            if (r.load) begin
                rd(REG_SERIAL_BUFFER);
                chk("rx byte", {3'h0, r.data}, {3'h0, rd_q});
                rd(REG_SERIAL_CONTROL);
                chk_flag("rx ninth", r.ninth, rd_q[SC_RX_NINTH]);
            end
            wr(REG_SERIAL_BUFFER, r.data);
            chk_flag("tx_done early", 1'b0, tx_done_o);
            exp_f = {1'b1, r.mode[1] ? r.ninth : 1'b1, r.data, 1'b0};
            u_peer.catch(per, got);
            chk("tx frame", exp_f, got);
            chk_flag("tx_done", 1'b1, tx_done_o);
            $display("test row %0d done", i);
        end
        wr(REG_POWER_CONTROL, 8'hc0);
        rd(REG_SERIAL_CONTROL);
        chk_flag("frame error", 1'b1, rd_q[SC_MODE_UPPER]);
        wr(REG_SERIAL_CONTROL, 8'h00);
        rd(REG_SERIAL_CONTROL);
        chk_flag("frame error clear", 1'b0, rd_q[SC_MODE_UPPER]);
        wr(REG_POWER_CONTROL, 8'h80);
        rd(REG_SERIAL_CONTROL);
        chk_flag("mode upper", 1'b1, rd_q[SC_MODE_UPPER]);
        rx_frame(32, 8'h69, 1'b0);
        chk_flag("rx off", 1'b0, rx_done_o);
        wr(REG_SERIAL_CONTROL, 8'h90);
        u_peer.send(1, 8, 11'h000);
        repeat (40) @(posedge clk_i);
        chk_flag("false start", 1'b0, rx_done_o);
        rx_frame(32, 8'h5a, 1'b0);
        chk_flag("rx rearm", 1'b1, rx_done_o);
        rx_frame(32, 8'hc3, 1'b0);
        chk_flag("rx held", 1'b1, rx_done_o);
        rd(REG_SERIAL_BUFFER);
        chk("rx kept", 11'h05a, {3'h0, rd_q});
        $display("test awkward cases done");
        close_out();
    end
endmodule : async_serial_port_multiproc_tb_top
`default_nettype wire
